//--- rtl/cbsock_pkg.sv
// Overview of operation
// - Event bits set on their conditions no matter what the mask holds.
// - Mask bit 3 lets a power-cycle event raise the status-change interrupt.
// - Mask bits 2:1 equal 11 enable detect events; 00 blocks; 01/10 reserved.
// - Mask bit 0 lets a card status-change event raise the interrupt.
// - Mask bits 31:4 and present-state bits 26:14 read zero.
// - Mask is power context: global reset only while the event function is on.
// - Present state shows live socket status and values forced by software.
// - Card type bits refresh only at card insertion or on a forced retest (force bit 14); voltage bits also take forced 1s.
// - Detect pin changes during card identification do not reach present state.
// - Future-voltage socket bits 31:30 read 0 unless forced.
// - Bit 29, low-voltage socket capability, reads 1 unless forced.
// - Bit 28, high-voltage socket capability, reads 1 unless device control bit 6.
// - Bit 27 shows zoomed-video support, 1 meaning enabled.
// - Bits 13:10 show card voltage support; a forced 1 sets each.
// - Bit 9 reads 1 during an invalid supply request or while forced to 1, otherwise 0.
// - Present state is read-only; reset shows bits 29 and 28 set plus live pins.
// - A set event bit with its mask enabled raises the status-change interrupt.
// - Status-change event: rising edge for CardBus cards, both edges for 16-bit cards.
// - Present-state bit 3 shows socket power, 0 when powered down.
// - Bits 2:1 mirror the detect pins, bit 0 the status-change pin level.
package cbsock_pkg;

	// ==========================================================
	// Register map
	localparam logic [7:0]  OFS_EVENT      = 8'h00;
	localparam logic [7:0]  OFS_MASK       = 8'h04;
	localparam logic [7:0]  OFS_PRESENT    = 8'h08;
	localparam logic [31:0] MASK_RESET     = 32'h0000_0000;

	// ==========================================================
	// Event and mask bit positions
	localparam int EV_STATUS   = 0;
	localparam int EV_DETECT1  = 1;
	localparam int EV_DETECT2  = 2;
	localparam int EV_POWER    = 3;
	localparam int EV_COUNT    = 4;
	localparam logic [1:0] CD_MASK_ON = 2'h3;

	// ==========================================================
	// Present-state bit positions
	localparam int PS_CARD_STATUS   = 0;
	localparam int PS_DETECT1       = 1;
	localparam int PS_DETECT2       = 2;
	localparam int PS_POWERED       = 3;
	localparam int PS_CARD_16BIT    = 4;
	localparam int PS_CARD_CARDBUS  = 5;
	localparam int PS_READY_IRQ     = 6;
	localparam int PS_BAD_SUPPLY    = 9;
	localparam int PS_CARD_VOLT_LO  = 10;
	localparam int PS_CARD_VOLT_HI  = 13;
	localparam int PS_ZOOMED        = 27;
	localparam int PS_HIGH_VOLT     = 28;
	localparam int PS_LOW_VOLT      = 29;
	localparam int PS_FUTURE_X      = 30;
	localparam int PS_FUTURE_Y      = 31;
	localparam int FORCE_CVSTEST    = 14;

	// ==========================================================
	// Timing
	localparam int CLK_MHZ           = 50;
	localparam int IDENTIFY_TIME_US  = 20;
	localparam int IDENTIFY_CYCLES   = IDENTIFY_TIME_US * CLK_MHZ;

	typedef struct packed {
		logic        sel;
		logic        wr;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} reg_req_s;

	typedef struct packed {
		logic        wr;
		logic [31:0] data;
	} force_req_s;

	typedef struct packed {
		logic       card_detect_pin_1;
		logic       card_detect_pin_2;
		logic       card_status_change_pin;
		logic       ready_irq_pin;
		logic       socket_powered;
		logic       invalid_supply_request;
		logic       card_is_cardbus;
		logic [3:0] card_volt_sense;
	} socket_pins_s;

endpackage : cbsock_pkg

//--- rtl/socket_event_track.sv
`timescale 1ns/1ps
module socket_event_track
	import cbsock_pkg::*;
#(
	parameter int N = EV_COUNT
) (
	input  wire logic         clk_sys_i,
	input  wire logic         ctx_rst_b_i,
	input  wire logic [N-1:0] watch_i,
	input  wire logic         cardbus_i,
	input  wire logic [N-1:0] clear_i,
	input  wire logic [N-1:0] force_i,
	output logic      [N-1:0] event_o
);

	logic [N-1:0] prev_r;
	logic [N-1:0] event_r;

	always_ff @(posedge clk_sys_i) begin
		if (!ctx_rst_b_i) begin
			// Load the idle pin levels so no false edge follows reset
			prev_r <= watch_i;
		end else begin
			prev_r <= watch_i;
		end
	end

	// ==========================================================
	// Per-bit sticky events, set beats clear
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_ev
			logic hit;
			if (g == EV_STATUS) begin : g_sts
				// CardBus cards report only the rising edge
				assign hit = cardbus_i ? (watch_i[g] & ~prev_r[g])
				                       : (watch_i[g] ^ prev_r[g]);
			end else begin : g_lvl
				assign hit = watch_i[g] ^ prev_r[g];
			end
			always_ff @(posedge clk_sys_i) begin
				if (!ctx_rst_b_i) begin
					event_r[g] <= 1'b0;
				end else if (hit || force_i[g]) begin
					event_r[g] <= 1'b1;
				end else if (clear_i[g]) begin
					event_r[g] <= 1'b0;
				end
			end
		end
	endgenerate

	assign event_o = event_r;

endmodule : socket_event_track

//--- rtl/card_identify.sv
`timescale 1ns/1ps
module card_identify
	import cbsock_pkg::*;
#(
	parameter int CYCLES = IDENTIFY_CYCLES
) (
	input  wire logic clk_sys_i,
	input  wire logic rst_b_i,
	input  wire logic detect_1_i,
	input  wire logic detect_2_i,
	input  wire logic retest_i,
	output logic      busy_o,
	output logic      capture_o
);

	typedef enum logic [0:0] {ID_IDLE, ID_RUN} id_state_e;

	id_state_e   state_r;
	logic [15:0] count_r;
	logic        present_r;
	logic        capture_r;
	logic        present;
	logic        start;

	// Both detect pins low means a card may be present
	assign present = ~detect_1_i & ~detect_2_i;
	assign start   = (present & ~present_r) | retest_i;

	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			present_r <= 1'b0;
		end else begin
			present_r <= present;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			state_r   <= ID_IDLE;
			count_r   <= '0;
			capture_r <= 1'b0;
		end else begin
			capture_r <= 1'b0;
			case (state_r)
				ID_IDLE: begin
					if (start) begin
						state_r <= ID_RUN;
						count_r <= 16'(CYCLES - 1);
					end
				end
				ID_RUN: begin
					if (count_r == 16'h0000) begin
						state_r   <= ID_IDLE;
						capture_r <= 1'b1;
					end else begin
						count_r <= count_r - 16'h0001;
					end
				end
				default: begin
					state_r <= ID_IDLE;
				end
			endcase
		end
	end

	assign busy_o    = (state_r == ID_RUN);
	assign capture_o = capture_r;

endmodule : card_identify

//--- rtl/cardbus_socket_mask_state.sv
`timescale 1ns/1ps
module cardbus_socket_mask_state
	import cbsock_pkg::*;
#(
	parameter int ID_CYCLES = IDENTIFY_CYCLES
) (
	input  wire logic         clk_sys_i,
	input  wire logic         rst_b_i,
	input  wire logic         bus_reset_b_i,
	input  wire logic         power_management_event_en_i,
	input  wire logic         dev_ctrl_high_volt_off_i,
	input  wire logic         zoomed_video_enable_i,
	input  wire reg_req_s     reg_req_i,
	input  wire force_req_s   force_req_i,
	input  wire socket_pins_s pins_i,
	output logic [31:0]       reg_rdata_o,
	output logic              reg_ack_o,
	output logic              card_status_change_interrupt_o,
	output logic              identify_busy_o
);

	// ==========================================================
	// Resets
	logic ctx_rst_b;
	logic any_rst_b;

	// Context survives bus reset while the event function is on
	assign ctx_rst_b = rst_b_i & (bus_reset_b_i | power_management_event_en_i);
	assign any_rst_b = rst_b_i & bus_reset_b_i;

	// ==========================================================
	// Register decode
	logic wr_mask;
	logic wr_event;
	logic rd_any;

	assign wr_mask  = reg_req_i.sel & reg_req_i.wr & (reg_req_i.addr == OFS_MASK);
	assign wr_event = reg_req_i.sel & reg_req_i.wr & (reg_req_i.addr == OFS_EVENT);
	assign rd_any   = reg_req_i.sel & ~reg_req_i.wr;

	// ==========================================================
	// Socket mask
	logic       power_cycle_irq_mask_r;
	logic [1:0] card_detect_irq_mask_r;
	logic       status_change_irq_mask_r;

	always_ff @(posedge clk_sys_i) begin
		if (!ctx_rst_b) begin
			power_cycle_irq_mask_r   <= MASK_RESET[EV_POWER];
			card_detect_irq_mask_r   <= MASK_RESET[EV_DETECT2:EV_DETECT1];
			status_change_irq_mask_r <= MASK_RESET[EV_STATUS];
		end else if (wr_mask) begin
			// Bits above the mask field are dropped
			power_cycle_irq_mask_r   <= reg_req_i.wdata[EV_POWER];
			card_detect_irq_mask_r   <= reg_req_i.wdata[EV_DETECT2:EV_DETECT1];
			status_change_irq_mask_r <= reg_req_i.wdata[EV_STATUS];
		end
	end

	// ==========================================================
	// Card identification
	logic identify_busy;
	logic identify_capture;
	logic retest;

	assign retest = force_req_i.wr & force_req_i.data[FORCE_CVSTEST];

	card_identify #(
		.CYCLES (ID_CYCLES)
	) u_identify (
		.clk_sys_i  (clk_sys_i),
		.rst_b_i    (any_rst_b),
		.detect_1_i (pins_i.card_detect_pin_1),
		.detect_2_i (pins_i.card_detect_pin_2),
		.retest_i   (retest),
		.busy_o     (identify_busy),
		.capture_o  (identify_capture)
	);

	// ==========================================================
	// Live socket status
	logic card_detect_state_1_r;
	logic card_detect_state_2_r;
	logic card_status_level_r;
	logic ready_irq_r;
	logic socket_powered_r;

	always_ff @(posedge clk_sys_i) begin
		if (!any_rst_b) begin
			card_detect_state_1_r <= 1'b1;
			card_detect_state_2_r <= 1'b1;
		end else if (!identify_busy) begin
			// Pins are borrowed while a card is being identified
			card_detect_state_1_r <= pins_i.card_detect_pin_1;
			card_detect_state_2_r <= pins_i.card_detect_pin_2;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!any_rst_b) begin
			card_status_level_r <= 1'b0;
			ready_irq_r         <= 1'b0;
			socket_powered_r    <= 1'b0;
		end else begin
			card_status_level_r <= pins_i.card_status_change_pin;
			ready_irq_r         <= pins_i.ready_irq_pin;
			socket_powered_r    <= pins_i.socket_powered;
		end
	end

	// ==========================================================
	// Capabilities captured at insertion or forced
	logic [3:0] card_volt_r;
	logic       card_cardbus_r;
	logic       card_16bit_r;
	logic       future_y_volt_socket_r;
	logic       future_x_volt_socket_r;
	logic       low_volt_socket_r;
	logic       zoomed_forced_r;
	logic       zoomed_force_val_r;
	logic       invalid_forced_r;
	logic       invalid_supply_r;

	always_ff @(posedge clk_sys_i) begin
		if (!any_rst_b) begin
			card_volt_r    <= 4'h0;
			card_cardbus_r <= 1'b0;
			card_16bit_r   <= 1'b0;
		end else if (identify_capture) begin
			card_volt_r    <= pins_i.card_volt_sense;
			card_cardbus_r <= pins_i.card_is_cardbus;
			card_16bit_r   <= ~pins_i.card_is_cardbus;
		end else if (force_req_i.wr) begin
			card_volt_r <= card_volt_r
				| force_req_i.data[PS_CARD_VOLT_HI:PS_CARD_VOLT_LO];
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!any_rst_b) begin
			future_y_volt_socket_r <= 1'b0;
			future_x_volt_socket_r <= 1'b0;
			low_volt_socket_r      <= 1'b1;
		end else if (force_req_i.wr) begin
			future_y_volt_socket_r <= force_req_i.data[PS_FUTURE_Y];
			future_x_volt_socket_r <= force_req_i.data[PS_FUTURE_X];
			low_volt_socket_r      <= ~force_req_i.data[PS_LOW_VOLT];
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!any_rst_b) begin
			zoomed_forced_r    <= 1'b0;
			zoomed_force_val_r <= 1'b0;
			invalid_forced_r   <= 1'b0;
		end else if (force_req_i.wr) begin
			zoomed_forced_r    <= 1'b1;
			zoomed_force_val_r <= force_req_i.data[PS_ZOOMED];
			invalid_forced_r   <= force_req_i.data[PS_BAD_SUPPLY];
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!any_rst_b) begin
			invalid_supply_r <= 1'b0;
		end else begin
			invalid_supply_r <= pins_i.invalid_supply_request | invalid_forced_r;
		end
	end

	// ==========================================================
	// Present-state image
	logic [31:0] present;
	logic        zoomed_video_capable;

	assign zoomed_video_capable = zoomed_forced_r ? zoomed_force_val_r
	                                              : zoomed_video_enable_i;

	always_comb begin
		present                   = 32'h0000_0000;
		present[PS_FUTURE_Y]      = future_y_volt_socket_r;
		present[PS_FUTURE_X]      = future_x_volt_socket_r;
		present[PS_LOW_VOLT]      = low_volt_socket_r;
		present[PS_HIGH_VOLT]     = ~dev_ctrl_high_volt_off_i;
		present[PS_ZOOMED]        = zoomed_video_capable;
		present[PS_CARD_VOLT_HI:PS_CARD_VOLT_LO] = card_volt_r;
		present[PS_BAD_SUPPLY]    = invalid_supply_r;
		present[PS_READY_IRQ]     = ready_irq_r;
		present[PS_CARD_CARDBUS]  = card_cardbus_r;
		present[PS_CARD_16BIT]    = card_16bit_r;
		present[PS_POWERED]       = socket_powered_r;
		present[PS_DETECT2]       = card_detect_state_2_r;
		present[PS_DETECT1]       = card_detect_state_1_r;
		present[PS_CARD_STATUS]   = card_status_level_r;
	end

	// ==========================================================
	// Socket events
	logic [EV_COUNT-1:0] watch;
	logic [EV_COUNT-1:0] ev_clear;
	logic [EV_COUNT-1:0] ev_force;
	logic [EV_COUNT-1:0] event_bits;

	assign watch    = {socket_powered_r, card_detect_state_2_r,
	                   card_detect_state_1_r, card_status_level_r};
	assign ev_clear = wr_event ? reg_req_i.wdata[EV_COUNT-1:0] : '0;
	assign ev_force = force_req_i.wr ? force_req_i.data[EV_COUNT-1:0] : '0;

	socket_event_track #(
		.N (EV_COUNT)
	) u_events (
		.clk_sys_i   (clk_sys_i),
		.ctx_rst_b_i (ctx_rst_b),
		.watch_i     (watch),
		.cardbus_i   (card_cardbus_r),
		.clear_i     (ev_clear),
		.force_i     (ev_force),
		.event_o     (event_bits)
	);

	// ==========================================================
	// Interrupt
	logic [EV_COUNT-1:0] irq_enable;
	logic                cd_enable;

	// Reserved detect-mask codes act as disabled
	assign cd_enable = (card_detect_irq_mask_r == CD_MASK_ON);

	always_comb begin
		irq_enable             = '0;
		irq_enable[EV_POWER]   = power_cycle_irq_mask_r;
		irq_enable[EV_DETECT2] = cd_enable;
		irq_enable[EV_DETECT1] = cd_enable;
		irq_enable[EV_STATUS]  = status_change_irq_mask_r;
	end

	always_ff @(posedge clk_sys_i) begin
		if (!ctx_rst_b) begin
			card_status_change_interrupt_o <= 1'b0;
		end else begin
			card_status_change_interrupt_o <= |(event_bits & irq_enable);
		end
	end

	// ==========================================================
	// Read path
	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			reg_rdata_o <= 32'h0000_0000;
			reg_ack_o   <= 1'b0;
		end else begin
			reg_ack_o <= reg_req_i.sel;
			if (rd_any) begin
				case (reg_req_i.addr)
					OFS_EVENT:   reg_rdata_o <= 32'(event_bits);
					OFS_MASK:    reg_rdata_o <= {28'h0000000, power_cycle_irq_mask_r,
					                card_detect_irq_mask_r, status_change_irq_mask_r};
					OFS_PRESENT: reg_rdata_o <= present;
					default:     reg_rdata_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!any_rst_b) begin
			identify_busy_o <= 1'b0;
		end else begin
			identify_busy_o <= identify_busy;
		end
	end

endmodule : cardbus_socket_mask_state

//--- dv/cbsock_assertions.sv
`timescale 1ns/1ps
module cbsock_checker
	import cbsock_pkg::*;
#(
	parameter int ID_CYCLES = IDENTIFY_CYCLES
) (
	input wire logic         clk_sys_i,
	input wire logic         rst_b_i,
	input wire logic         bus_reset_b_i,
	input wire logic         power_management_event_en_i,
	input wire logic         dev_ctrl_high_volt_off_i,
	input wire logic         zoomed_video_enable_i,
	input wire reg_req_s     reg_req_i,
	input wire force_req_s   force_req_i,
	input wire socket_pins_s pins_i,
	input wire logic [31:0]  reg_rdata_o,
	input wire logic         reg_ack_o,
	input wire logic         card_status_change_interrupt_o,
	input wire logic         identify_busy_o
);
	// ==========================================
	// Helpers
	logic       rd_c;
	logic       rd_p;
	logic       wr_m;
	logic [3:0] msk_r;
	int         busy_cnt_r;

	assign rd_c = reg_req_i.sel && !reg_req_i.wr;
	assign rd_p = rd_c && reg_req_i.addr == OFS_PRESENT;
	assign wr_m = reg_req_i.sel && reg_req_i.wr && reg_req_i.addr == OFS_MASK;

	function automatic logic en(input logic [3:0] m);
		return m[3] | m[0] | (m[2:1] == CD_MASK_ON);
	endfunction : en

	// Mirror of the mask, so the interrupt can be tied to it
	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i || (!bus_reset_b_i && !power_management_event_en_i)) begin
			msk_r <= 4'h0;
		end else if (wr_m) begin
			msk_r <= reg_req_i.wdata[3:0];
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i || !bus_reset_b_i || !identify_busy_o) begin
			busy_cnt_r <= 0;
		end else begin
			busy_cnt_r <= busy_cnt_r + 1;
		end
	end

	// ==========================================
	// Properties
	default clocking cbk @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i || !bus_reset_b_i);

	a_ack_timing: assert property (reg_ack_o == $past(reg_req_i.sel))
		else $error("ack not one cycle after request");
	a_mask_rsvd: assert property (rd_c && reg_req_i.addr == OFS_MASK
		|=> reg_rdata_o[31:4] == 28'h0) else $error("mask reserved bits set");
	a_present_rsvd: assert property (rd_p |=> reg_rdata_o[26:14] == 13'h0)
		else $error("present reserved bits set");
	a_high_volt: assert property (rd_p && $stable(dev_ctrl_high_volt_off_i)
		|=> reg_rdata_o[28] != $past(dev_ctrl_high_volt_off_i)) else $error("bit 28 wrong");
	a_irq_needs_mask: assert property ($rose(card_status_change_interrupt_o)
		|-> en(msk_r) || en($past(msk_r))) else $error("interrupt while masked");
	a_irq_mask_off: assert property (wr_m && reg_req_i.wdata[3:0] == 4'h0
		|=> ##1 !card_status_change_interrupt_o) else $error("interrupt after mask off");
	a_ctx_kept: assert property (disable iff (!rst_b_i)
		!bus_reset_b_i && power_management_event_en_i && card_status_change_interrupt_o
		&& !reg_req_i.sel |=> card_status_change_interrupt_o) else $error("context lost");
	a_bus_clr: assert property (disable iff (!rst_b_i)
		!bus_reset_b_i && !power_management_event_en_i |=> !card_status_change_interrupt_o)
		else $error("interrupt kept over bus reset");
	a_busy_len: assert property ($fell(identify_busy_o) |-> busy_cnt_r == ID_CYCLES)
		else $error("identification length wrong");
	a_rdata_hold: assert property (!rd_c |=> $stable(reg_rdata_o))
		else $error("read data changed without read");
endmodule : cbsock_checker

//--- dv/cbsock_card_model.sv
`timescale 1ns/1ps
module cbsock_card_model
	import cbsock_pkg::*;
(
	input  wire logic       clk_sys_i,
	input  wire logic       inserted_i,
	input  wire logic       cardbus_i,
	input  wire logic [3:0] volts_i,
	input  wire logic       status_i,
	input  wire logic       powered_i,
	input  wire logic       bad_req_i,
	input  wire logic       bounce_i,
	output socket_pins_s    pins_o
);
	// Empty socket: detect and sense lines sit on their pull-ups
	initial pins_o = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 4'hF};

	// Pins move just after the falling edge, clear of the sampling edge
	always @(negedge clk_sys_i) begin
		pins_o.card_detect_pin_1 <= !inserted_i;
		pins_o.card_detect_pin_2 <= !inserted_i || bounce_i;
		pins_o.card_status_change_pin <= inserted_i && status_i;
		pins_o.ready_irq_pin <= inserted_i;
		pins_o.socket_powered <= powered_i;
		pins_o.invalid_supply_request <= bad_req_i;
		pins_o.card_is_cardbus <= inserted_i && cardbus_i;
		pins_o.card_volt_sense <= inserted_i ? volts_i : 4'hF;
	end
endmodule : cbsock_card_model

//--- dv/cardbus_socket_mask_state_tb.sv
`timescale 1ns/1ps
module cardbus_socket_mask_state_tb;
	import cbsock_pkg::*;
	localparam int IDC = 8;
	logic         clk_sys_i, rst_b_i, bus_reset_b_i, pme_en, hv_off, zv_en;
	logic         ack, irq, busy, ins, cb, st, pwr, bad, bnc;
	logic [3:0]   vlt;
	logic [31:0]  rdata, q;
	reg_req_s     req;
	force_req_s   frq;
	socket_pins_s pins;
	int           errors, comparisons;
	logic [3:0]   codes [6] = '{4'h0, 4'h8, 4'h6, 4'h2, 4'h4, 4'h1};

	cardbus_socket_mask_state #(.ID_CYCLES(IDC)) i_cardbus_socket_mask_state (
		.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .bus_reset_b_i(bus_reset_b_i),
		.power_management_event_en_i(pme_en), .dev_ctrl_high_volt_off_i(hv_off),
		.zoomed_video_enable_i(zv_en), .reg_req_i(req), .force_req_i(frq), .pins_i(pins),
		.reg_rdata_o(rdata), .reg_ack_o(ack), .card_status_change_interrupt_o(irq),
		.identify_busy_o(busy));
	cbsock_card_model i_cbsock_card_model (.clk_sys_i(clk_sys_i), .inserted_i(ins),
		.cardbus_i(cb), .volts_i(vlt), .status_i(st), .powered_i(pwr), .bad_req_i(bad),
		.bounce_i(bnc), .pins_o(pins));

	always #10 clk_sys_i = ~clk_sys_i;

	// ==========================================
	// Tasks
	task automatic give_verdict();
		if (errors == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : give_verdict

	task automatic cmp(input logic [31:0] got, input logic [31:0] e, input logic [31:0] m);
		comparisons++;
		if ((got & m) !== (e & m)) begin
			errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, e);
		end
	endtask : cmp

	task automatic irq_is(input logic e);
		cmp({31'h0, irq}, {31'h0, e}, 32'h1);
	endtask : irq_is

	task automatic tick(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask : tick

	task automatic stuck(input int n);
		if (n == 40) begin
			errors++;
			$display("[ERR] %0t wait ran out", $time);
			give_verdict();
		end
	endtask : stuck

	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(negedge clk_sys_i);
		req <= '{1'b1, w, a, d};
		@(negedge clk_sys_i);
		req.sel <= 1'b0;
		while (ack !== 1'b1 && n < 40) begin
			@(negedge clk_sys_i);
			n++;
		end
		stuck(n);
		q = rdata;
	endtask : acc

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		acc(1'b0, a, 32'h0);
		cmp(q, e, m);
	endtask : rd

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		acc(1'b1, a, d);
	endtask : wr

	task automatic frc(input logic [31:0] d);
		@(negedge clk_sys_i);
		frq <= '{1'b1, d};
		@(negedge clk_sys_i);
		frq.wr <= 1'b0;
	endtask : frc

	task automatic wait_busy(input logic lvl);
		int n;
		n = 0;
		while (busy !== lvl && n < 40) begin
			@(negedge clk_sys_i);
			n++;
		end
		stuck(n);
	endtask : wait_busy

	task automatic pulse_bus_reset();
		bus_reset_b_i = 1'b0;
		tick(1);
		bus_reset_b_i = 1'b1;
	endtask : pulse_bus_reset

	// ==========================================
	// Sequence
	initial begin
		clk_sys_i = 0; rst_b_i = 0; bus_reset_b_i = 0; pme_en = 0; hv_off = 0; zv_en = 0;
		{ins, cb, st, pwr, bad, bnc} = 6'h00; vlt = 4'h0; req = '0; frq = '0;
		errors = 0; comparisons = 0;
		tick(2);
		rst_b_i = 1; bus_reset_b_i = 1;
		tick(2);
		rd(OFS_MASK, 32'h0, 32'hFFFF_FFFF);
		rd(OFS_PRESENT, 32'h3000_0006, 32'hFFFF_FFFF);
		zv_en = 1; hv_off = 1; tick(2);
		rd(OFS_PRESENT, 32'h0800_0000, 32'h1800_0000);
		hv_off = 0;
		wr(OFS_MASK, 32'hFFFF_FFFF);
		rd(OFS_MASK, 32'hF, 32'hFFFF_FFFF);
		wr(OFS_PRESENT, 32'hFFFF_FFFF);
		rd(OFS_PRESENT, 32'h3800_0006, 32'hFFFF_FFFF);
		rd(8'h40, 32'h0, 32'hFFFF_FFFF);
		wr(OFS_MASK, 32'h8); wr(OFS_EVENT, 32'hF);
		pwr = 1; tick(4);
		irq_is(1'b1);
		rd(OFS_PRESENT, 32'h8, 32'h8);
		rd(OFS_EVENT, 32'h8, 32'hF);
		foreach (codes[i]) begin
			wr(OFS_MASK, {28'h0, codes[i]}); wr(OFS_EVENT, 32'hF); frc(32'hF); tick(3);
			irq_is(codes[i][3] | codes[i][0] | (codes[i][2:1] == 2'h3));
			rd(OFS_EVENT, 32'hF, 32'hF);
		end
		wr(OFS_MASK, 32'hF); tick(3);
		pme_en = 1; pulse_bus_reset();
		irq_is(1'b1);
		rd(OFS_MASK, 32'hF, 32'hFFFF_FFFF);
		pme_en = 0; pulse_bus_reset();
		rd(OFS_MASK, 32'h0, 32'hFFFF_FFFF);
		wr(OFS_MASK, 32'hF); pme_en = 1; rst_b_i = 0; tick(1); rst_b_i = 1;
		rd(OFS_MASK, 32'h0, 32'hFFFF_FFFF);
		pme_en = 0; wr(OFS_MASK, 32'h1);
		// CardBus card: type and volts latched once, detect frozen while identifying
		cb = 1; vlt = 4'h5; ins = 1; wait_busy(1'b1);
		bnc = 1; tick(2);
		rd(OFS_PRESENT, 32'h0, 32'h6);
		bnc = 0; wait_busy(1'b0); tick(2);
		rd(OFS_PRESENT, 32'h1468, 32'h3E7F);
		vlt = 4'hA; wr(OFS_EVENT, 32'hF); tick(3);
		rd(OFS_PRESENT, 32'h1400, 32'h3C00);
		st = 1; tick(4);
		irq_is(1'b1);
		rd(OFS_PRESENT, 32'h1, 32'h1);
		wr(OFS_EVENT, 32'hF); st = 0; tick(4);
		irq_is(1'b0);
		ins = 0; tick(4); cb = 0; ins = 1; wait_busy(1'b1); wait_busy(1'b0);
		st = 1; tick(4); wr(OFS_EVENT, 32'hF); tick(3); st = 0; tick(4);
		irq_is(1'b1);
		rd(OFS_PRESENT, 32'h10, 32'h30);
		bad = 1; tick(2);
		rd(OFS_PRESENT, 32'h200, 32'h200);
		bad = 0; tick(2);
		rd(OFS_PRESENT, 32'h0, 32'h200);
		frc(32'hE800_3E00); tick(2);
		rd(OFS_PRESENT, 32'hD800_3E00, 32'hF800_3E00);
		frc(32'h0); tick(2);
		rd(OFS_PRESENT, 32'h3000_3C00, 32'hF800_3E00);
		give_verdict();
	end
endmodule : cardbus_socket_mask_state_tb

bind cardbus_socket_mask_state cbsock_checker #(.ID_CYCLES(ID_CYCLES)) i_cbsock_checker (
	.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .bus_reset_b_i(bus_reset_b_i),
	.power_management_event_en_i(power_management_event_en_i),
	.dev_ctrl_high_volt_off_i(dev_ctrl_high_volt_off_i),
	.zoomed_video_enable_i(zoomed_video_enable_i), .reg_req_i(reg_req_i),
	.force_req_i(force_req_i), .pins_i(pins_i), .reg_rdata_o(reg_rdata_o),
	.reg_ack_o(reg_ack_o), .card_status_change_interrupt_o(card_status_change_interrupt_o),
	.identify_busy_o(identify_busy_o));
